// [logic/header_compose.sv]
// Composes the header bytes of one message from the stored header values.
// Assumes its inputs are stable registers of the same clock domain.
`timescale 1ns/1ps
module header_compose (
   hdr_if.build h
);

   // Byte 0 goes out first; unused positions read as zero.
   always_comb begin
      h.hdrByte    = '0;
      h.hdrLen     = 3'd3;
      h.functional = 1'b0;
      case (h.mode)
         obd_hdr_pkg::MODE_BASIC: begin
            h.hdrByte[0] = h.hdr[23:16];
            h.hdrByte[1] = h.hdr[15:8];
            h.hdrByte[2] = h.hdr[7:0];
         end
         obd_hdr_pkg::MODE_KWP: begin
            h.hdrByte[1] = h.hdr[15:8];
            h.hdrByte[2] = h.hdr[7:0];
            if (h.hdr[21:16] == 6'd0) begin
               h.hdrByte[0] = {h.hdr[23:22], 6'd0};
               h.hdrByte[3] = {5'd0, h.count};
               h.hdrLen     = 3'd4;
            end else begin
               h.hdrByte[0] = {h.hdr[23:22], 3'd0, h.count};
            end
         end
         obd_hdr_pkg::MODE_CAN29: begin
            h.hdrByte[0] = {3'd0, h.prio[4:0]};
            h.hdrByte[1] = h.hdr[23:16];
            h.hdrByte[2] = h.hdr[15:8];
            h.hdrByte[3] = h.hdr[7:0];
            h.hdrLen     = 3'd4;
            h.functional = (h.hdr[23:16] == obd_hdr_pkg::TYPE_FUNCTIONAL) &&
                           (h.hdr[15:8] == obd_hdr_pkg::FUNC_TARGET) &&
                           (h.hdr[7:0] == obd_hdr_pkg::FUNC_SOURCE);
         end
         obd_hdr_pkg::MODE_CAN11: begin
            h.hdrByte[0] = {5'd0, h.hdr[10:8]};
            h.hdrByte[1] = h.hdr[7:0];
            h.hdrLen     = 3'd2;
            h.functional = (h.hdr[10:0] == obd_hdr_pkg::ID11_FUNCTIONAL);
         end
         default: begin
            h.hdrLen = 3'd3;
         end
      endcase
   end

endmodule

// [logic/obd_header_id_builder.sv]
// Diagnostic request framer: header storage, APB registers, byte sequencer and
// reply timeout.
// Assumes an APB master on clock, a byte sink on txReady in the same domain and
// an asynchronous reply-detected level on replyIn from the bus receiver.
`timescale 1ns/1ps
module obd_header_id_builder #(
   parameter int TICK_CYCLES = obd_hdr_pkg::TICK_CYCLES
) (
   input  wire logic        clock,
   input  wire logic        rst,
   input  wire logic [7:0]  paddr,
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [31:0] pwdata,
   output logic      [31:0] prdata,
   output logic             pready,
   output logic             pslverr,
   input  wire logic        replyIn,
   output logic      [7:0]  txData,
   output logic             txValid,
   output logic             txFirst,
   output logic             txLast,
   input  wire logic        txReady,
   output logic             headerOk,
   output logic             noReply,
   output logic             headerDisplay
);

   // Software-visible storage.
   obd_hdr_pkg::proto_mode_e mode_q;
   logic [23:0]              hdr_q;
   logic [7:0]               prio_q;
   logic [7:0]               tmo_q;
   logic                     show_q;
   logic [7:0]               data_q [0:6];
   logic [2:0]               count_q;
   logic                     go_q;
   logic                     okSt_q;
   logic                     noReplySt_q;
   logic                     replySt_q;
   logic                     headerOk_q;

   // APB answer registers.
   logic [31:0] prdata_q;
   logic        pslverr_q;
   logic [31:0] readData;

   // Sequencer state.
   obd_hdr_pkg::seq_state_e state_q;
   logic [3:0][7:0]         headLatch_q;
   logic [2:0]              headLen_q;
   logic                    isCan_q;
   logic [2:0]              idx_q;
   logic [7:0]              sum_q;
   logic [7:0]              txData_q;
   logic                    txValid_q;
   logic                    txFirst_q;
   logic                    txLast_q;
   logic [31:0]             tickCnt_q;
   logic [7:0]              tmoLeft_q;

   // Reply input synchroniser.
   logic replyS1_q;
   logic replyS2_q;
   logic replyS3_q;
   logic replyLvl_q;

   // Decoded strobes and events.
   logic setup;
   logic wrEn;
   logic idle;
   logic canAdvance;
   logic tickDone;
   logic replyRise;
   logic replyEvt;
   logic noReplyEvt;
   logic hdrWrite;
   logic defaultsWrite;

   hdr_if hb ();

   // True for every register offset that the slave answers.
   function automatic logic isMapped(input logic [7:0] a);
      case (a)
         obd_hdr_pkg::OFS_CTRL, obd_hdr_pkg::OFS_HDR, obd_hdr_pkg::OFS_HDR4,
         obd_hdr_pkg::OFS_HDR11, obd_hdr_pkg::OFS_PRIO, obd_hdr_pkg::OFS_TMO,
         obd_hdr_pkg::OFS_STATUS, obd_hdr_pkg::OFS_SEND, obd_hdr_pkg::OFS_DATA0,
         obd_hdr_pkg::OFS_DATA1: isMapped = 1'b1;
         default: isMapped = 1'b0;
      endcase
   endfunction

   // The composer sees the live header storage and the pending data count.
   assign hb.mode  = mode_q;
   assign hb.hdr   = hdr_q;
   assign hb.prio  = prio_q;
   assign hb.count = count_q;

   header_compose composer (
      .h (hb.build)
   );

   // Bus strobes; the slave never inserts wait states.
   assign setup         = psel & ~penable;
   assign wrEn          = psel & penable & pwrite & isMapped(paddr);
   assign idle          = (state_q == obd_hdr_pkg::SEQ_IDLE) & ~go_q;
   assign hdrWrite      = wrEn & ((paddr == obd_hdr_pkg::OFS_HDR) |
                                  (paddr == obd_hdr_pkg::OFS_HDR4) |
                                  (paddr == obd_hdr_pkg::OFS_HDR11) |
                                  (paddr == obd_hdr_pkg::OFS_PRIO));
   assign defaultsWrite = wrEn & (paddr == obd_hdr_pkg::OFS_CTRL) &
                          pwdata[obd_hdr_pkg::CTRL_DEFAULT_BIT];

   // Outputs of the bus and the byte stream.
   assign pready        = 1'b1;
   assign pslverr       = pslverr_q & psel & penable;
   assign prdata        = prdata_q;
   assign txData        = txData_q;
   assign txValid       = txValid_q;
   assign txFirst       = txFirst_q;
   assign txLast        = txLast_q;
   assign headerOk      = headerOk_q;
   assign noReply       = noReplySt_q;
   assign headerDisplay = show_q;

   // Read multiplexer, sampled in the setup cycle.
   always_comb begin
      readData = 32'h0000_0000;
      case (paddr)
         obd_hdr_pkg::OFS_CTRL: begin
            readData[obd_hdr_pkg::CTRL_MODE_LSB +: 2] = mode_q;
            readData[obd_hdr_pkg::CTRL_SHOW_BIT]      = show_q;
         end
         obd_hdr_pkg::OFS_HDR:   readData[23:0] = hdr_q;
         obd_hdr_pkg::OFS_HDR4:  readData = {prio_q, hdr_q};
         obd_hdr_pkg::OFS_HDR11: readData[10:0] = hdr_q[10:0];
         obd_hdr_pkg::OFS_PRIO:  readData[7:0] = prio_q;
         obd_hdr_pkg::OFS_TMO:   readData[7:0] = tmo_q;
         obd_hdr_pkg::OFS_STATUS: begin
            readData[obd_hdr_pkg::ST_OK_BIT]      = okSt_q;
            readData[obd_hdr_pkg::ST_NOREPLY_BIT] = noReplySt_q;
            readData[obd_hdr_pkg::ST_REPLY_BIT]   = replySt_q;
            readData[obd_hdr_pkg::ST_BUSY_BIT]    = ~idle;
            readData[obd_hdr_pkg::ST_FUNC_BIT]    = hb.functional;
         end
         obd_hdr_pkg::OFS_SEND:  readData[obd_hdr_pkg::SEND_COUNT_LSB +: 3] = count_q;
         obd_hdr_pkg::OFS_DATA0: readData = {data_q[3], data_q[2], data_q[1], data_q[0]};
         obd_hdr_pkg::OFS_DATA1: readData = {8'h00, data_q[6], data_q[5], data_q[4]};
         default:                readData = 32'h0000_0000;
      endcase
   end

   // Read data and error flag are registered so they stand through the access.
   always_ff @(posedge clock) begin
      if (rst) begin
         prdata_q  <= 32'h0000_0000;
         pslverr_q <= 1'b0;
      end else if (setup) begin
         prdata_q  <= pwrite ? 32'h0000_0000 : readData;
         pslverr_q <= ~isMapped(paddr);
      end
   end

   // Header storage; it changes only on a header write, defaults or reset.
   always_ff @(posedge clock) begin
      if (rst) begin
         hdr_q  <= obd_hdr_pkg::HDR_RESET;
         prio_q <= obd_hdr_pkg::PRIO_RESET;
      end else if (defaultsWrite) begin
         hdr_q  <= obd_hdr_pkg::HDR_RESET;
         prio_q <= obd_hdr_pkg::PRIO_RESET;
      end else if (wrEn) begin
         case (paddr)
            obd_hdr_pkg::OFS_HDR:   hdr_q <= pwdata[23:0];
            obd_hdr_pkg::OFS_HDR4: begin
               prio_q <= pwdata[31:24];
               hdr_q  <= pwdata[23:0];
            end
            obd_hdr_pkg::OFS_HDR11: hdr_q <= {13'h0000, pwdata[10:0]};
            obd_hdr_pkg::OFS_PRIO:  prio_q <= pwdata[7:0];
            default:                hdr_q <= hdr_q;
         endcase
      end
   end

   // Control and timeout settings.
   always_ff @(posedge clock) begin
      if (rst) begin
         mode_q <= obd_hdr_pkg::MODE_BASIC;
         show_q <= 1'b0;
         tmo_q  <= obd_hdr_pkg::TMO_RESET;
      end else if (wrEn && paddr == obd_hdr_pkg::OFS_CTRL) begin
         mode_q <= obd_hdr_pkg::proto_mode_e'(pwdata[obd_hdr_pkg::CTRL_MODE_LSB +: 2]);
         show_q <= defaultsWrite ? 1'b0 : pwdata[obd_hdr_pkg::CTRL_SHOW_BIT];
         if (defaultsWrite) begin
            tmo_q <= obd_hdr_pkg::TMO_RESET;
         end
      end else if (wrEn && paddr == obd_hdr_pkg::OFS_TMO) begin
         tmo_q <= pwdata[7:0];
      end
   end

   // Message data and launch; both are held off while a message is in flight.
   always_ff @(posedge clock) begin
      if (rst) begin
         count_q <= 3'd0;
         go_q    <= 1'b0;
         for (int i = 0; i < 7; i++) begin
            data_q[i] <= 8'h00;
         end
      end else begin
         go_q <= 1'b0;
         if (wrEn && idle) begin
            if (paddr == obd_hdr_pkg::OFS_DATA0) begin
               for (int i = 0; i < 4; i++) begin
                  data_q[i] <= pwdata[8*i +: 8];
               end
            end
            if (paddr == obd_hdr_pkg::OFS_DATA1) begin
               for (int i = 0; i < 3; i++) begin
                  data_q[4+i] <= pwdata[8*i +: 8];
               end
            end
            if (paddr == obd_hdr_pkg::OFS_SEND &&
                pwdata[obd_hdr_pkg::SEND_COUNT_LSB +: 3] != 3'd0) begin
               count_q <= pwdata[obd_hdr_pkg::SEND_COUNT_LSB +: 3];
               go_q    <= 1'b1;
            end
         end
      end
   end

   // Sticky status flags and the one-cycle headerOk pulse; a hardware set wins over a clear in the same cycle.
   always_ff @(posedge clock) begin
      if (rst) begin
         okSt_q      <= 1'b0;
         noReplySt_q <= 1'b0;
         replySt_q   <= 1'b0;
         headerOk_q  <= 1'b0;
      end else begin
         headerOk_q <= hdrWrite;
         if (hdrWrite) begin
            okSt_q <= 1'b1;
         end else if (wrEn && paddr == obd_hdr_pkg::OFS_STATUS &&
                      pwdata[obd_hdr_pkg::ST_OK_BIT]) begin
            okSt_q <= 1'b0;
         end
         if (noReplyEvt) begin
            noReplySt_q <= 1'b1;
         end else if ((wrEn && paddr == obd_hdr_pkg::OFS_STATUS &&
                       pwdata[obd_hdr_pkg::ST_NOREPLY_BIT]) || go_q) begin
            noReplySt_q <= 1'b0;
         end
         if (replyEvt) begin
            replySt_q <= 1'b1;
         end else if ((wrEn && paddr == obd_hdr_pkg::OFS_STATUS &&
                       pwdata[obd_hdr_pkg::ST_REPLY_BIT]) || go_q) begin
            replySt_q <= 1'b0;
         end
      end
   end

   // Reply input: three stages, a change counts once stages two and three agree.
   always_ff @(posedge clock) begin
      if (rst) begin
         replyS1_q  <= 1'b0;
         replyS2_q  <= 1'b0;
         replyS3_q  <= 1'b0;
         replyLvl_q <= 1'b0;
      end else begin
         replyS1_q <= replyIn;
         replyS2_q <= replyS1_q;
         replyS3_q <= replyS2_q;
         if (replyS2_q == replyS3_q) begin
            replyLvl_q <= replyS3_q;
         end
      end
   end

   assign replyRise  = (replyS2_q == replyS3_q) & replyS3_q & ~replyLvl_q;
   assign tickDone   = (tickCnt_q == 32'(TICK_CYCLES - 1));
   assign replyEvt   = (state_q == obd_hdr_pkg::SEQ_WAIT) & replyRise;
   assign noReplyEvt = (state_q == obd_hdr_pkg::SEQ_WAIT) & ~replyRise & tickDone &
                       (tmoLeft_q == 8'h00);
   assign canAdvance = ~txValid_q | txReady;

   // Timeout prescaler, counting only while a reply is awaited.
   always_ff @(posedge clock) begin
      if (rst || state_q != obd_hdr_pkg::SEQ_WAIT || tickDone) begin
         tickCnt_q <= 32'h0000_0000;
      end else begin
         tickCnt_q <= tickCnt_q + 32'h0000_0001;
      end
   end

   // Sequencer: header bytes, data bytes, checksum outside the CAN modes, then wait for a reply.
   always_ff @(posedge clock) begin
      if (rst) begin
         state_q     <= obd_hdr_pkg::SEQ_IDLE;
         headLatch_q <= '0;
         headLen_q   <= 3'd0;
         isCan_q     <= 1'b0;
         idx_q       <= 3'd0;
         sum_q       <= 8'h00;
         txData_q    <= 8'h00;
         txValid_q   <= 1'b0;
         txFirst_q   <= 1'b0;
         txLast_q    <= 1'b0;
         tmoLeft_q   <= 8'h00;
      end else begin
         case (state_q)
            obd_hdr_pkg::SEQ_IDLE: begin
               if (go_q) begin
                  headLatch_q <= hb.hdrByte;
                  headLen_q   <= hb.hdrLen;
                  isCan_q     <= mode_q[1];
                  idx_q       <= 3'd0;
                  sum_q       <= 8'h00;
                  state_q     <= obd_hdr_pkg::SEQ_HEAD;
               end
            end
            obd_hdr_pkg::SEQ_HEAD: begin
               if (canAdvance) begin
                  txValid_q <= 1'b1;
                  txData_q  <= headLatch_q[idx_q[1:0]];
                  txFirst_q <= (idx_q == 3'd0);
                  txLast_q  <= 1'b0;
                  sum_q     <= sum_q + headLatch_q[idx_q[1:0]];
                  if (idx_q == headLen_q - 3'd1) begin
                     idx_q   <= 3'd0;
                     state_q <= obd_hdr_pkg::SEQ_DATA;
                  end else begin
                     idx_q <= idx_q + 3'd1;
                  end
               end
            end
            obd_hdr_pkg::SEQ_DATA: begin
               if (canAdvance) begin
                  txValid_q <= 1'b1;
                  txData_q  <= data_q[idx_q];
                  txFirst_q <= 1'b0;
                  txLast_q  <= isCan_q && (idx_q == count_q - 3'd1);
                  sum_q     <= sum_q + data_q[idx_q];
                  if (idx_q == count_q - 3'd1) begin
                     state_q <= isCan_q ? obd_hdr_pkg::SEQ_DRAIN : obd_hdr_pkg::SEQ_SUM;
                  end else begin
                     idx_q <= idx_q + 3'd1;
                  end
               end
            end
            obd_hdr_pkg::SEQ_SUM: begin
               if (canAdvance) begin
                  txData_q  <= sum_q;
                  txFirst_q <= 1'b0;
                  txLast_q  <= 1'b1;
                  state_q   <= obd_hdr_pkg::SEQ_DRAIN;
               end
            end
            obd_hdr_pkg::SEQ_DRAIN: begin
               if (txReady) begin
                  txValid_q <= 1'b0;
                  txLast_q  <= 1'b0;
                  tmoLeft_q <= tmo_q;
                  state_q   <= obd_hdr_pkg::SEQ_WAIT;
               end
            end
            obd_hdr_pkg::SEQ_WAIT: begin
               if (replyEvt || noReplyEvt) begin
                  state_q <= obd_hdr_pkg::SEQ_IDLE;
               end else if (tickDone) begin
                  tmoLeft_q <= tmoLeft_q - 8'h01;
               end
            end
            default: begin
               state_q   <= obd_hdr_pkg::SEQ_IDLE;
               txValid_q <= 1'b0;
            end
         endcase
      end
   end

endmodule

// [shared/hdr_if.sv]
// Interface between the header storage and the header composer.
// Assumes both ends run combinationally within one clock domain.
`timescale 1ns/1ps
interface hdr_if;
   obd_hdr_pkg::proto_mode_e mode;
   logic [23:0]              hdr;
   logic [7:0]               prio;
   logic [2:0]               count;
   logic [3:0][7:0]          hdrByte;
   logic [2:0]               hdrLen;
   logic                     functional;

   modport build (
      input  mode,
      input  hdr,
      input  prio,
      input  count,
      output hdrByte,
      output hdrLen,
      output functional
   );

   modport user (
      output mode,
      output hdr,
      output prio,
      output count,
      input  hdrByte,
      input  hdrLen,
      input  functional
   );
endinterface

// [shared/obd_hdr_pkg.sv]
// Constants, field layouts, reset values and enumerations of the header builder.
// Assumes a 25 MHz system clock and an APB master with 32-bit data.
//
// Summary of operation
// - Stored three header bytes lead every basic-mode message.
// - Header holds until rewritten, reset or defaults.
// - Priority, target, source; non-CAN checksum after data.
// - Second header byte is the target address.
// - Timeout up to FF; expiry flags no reply.
// - Fourteen-two-thirty: length fills first byte.
// - Zero low bits: fourth byte carries length.
// - 29-bit ID is priority plus header.
// - Priority defaults to 18, written separately.
// - Only priority low five bits are used.
// - Type byte DB functional, DA physical.
// - Then target address, then source address.
// - Functional 29-bit requests use 33 and F1.
// - Four-byte header write loads all 29 bits.
// - 11-bit ID uses low stored bits only.
// - Three-digit write drops the top bit.
// - Accepted header write is acknowledged OK.
// - 11-bit functional 7DF, physical 7En.
package obd_hdr_pkg;

   // Register byte offsets on the APB.
   localparam logic [7:0] OFS_CTRL   = 8'h00;
   localparam logic [7:0] OFS_HDR    = 8'h04;
   localparam logic [7:0] OFS_HDR4   = 8'h08;
   localparam logic [7:0] OFS_HDR11  = 8'h0C;
   localparam logic [7:0] OFS_PRIO   = 8'h10;
   localparam logic [7:0] OFS_TMO    = 8'h14;
   localparam logic [7:0] OFS_STATUS = 8'h18;
   localparam logic [7:0] OFS_SEND   = 8'h1C;
   localparam logic [7:0] OFS_DATA0  = 8'h20;
   localparam logic [7:0] OFS_DATA1  = 8'h24;

   // Field positions.
   localparam int CTRL_MODE_LSB    = 0;
   localparam int CTRL_SHOW_BIT    = 2;
   localparam int CTRL_DEFAULT_BIT = 3;
   localparam int ST_OK_BIT        = 0;
   localparam int ST_NOREPLY_BIT   = 1;
   localparam int ST_REPLY_BIT     = 2;
   localparam int ST_BUSY_BIT      = 3;
   localparam int ST_FUNC_BIT      = 4;
   localparam int SEND_COUNT_LSB   = 0;

   // Reset and default values.
   localparam logic [23:0] HDR_RESET  = 24'h00_0000;
   localparam logic [7:0]  PRIO_RESET = 8'h18;
   localparam logic [7:0]  TMO_RESET  = 8'hFF;

   // Addressing conventions.
   localparam logic [7:0]  TYPE_FUNCTIONAL = 8'hDB;
   localparam logic [7:0]  TYPE_PHYSICAL   = 8'hDA;
   localparam logic [7:0]  FUNC_TARGET     = 8'h33;
   localparam logic [7:0]  FUNC_SOURCE     = 8'hF1;
   localparam logic [10:0] ID11_FUNCTIONAL = 11'h7DF;
   localparam logic [7:0]  ID11_PHYS_HIGH  = 8'h7E;

   // Timeout tick: one timeout code step, in microseconds, and in cycles.
   localparam int CLOCK_MHZ    = 25;
   localparam int TICK_TIME_US = 1000;
   localparam int TICK_CYCLES  = TICK_TIME_US * CLOCK_MHZ;

   // Line protocol of the outgoing messages.
   typedef enum logic [1:0] {
      MODE_BASIC = 2'b00,
      MODE_KWP   = 2'b01,
      MODE_CAN29 = 2'b10,
      MODE_CAN11 = 2'b11
   } proto_mode_e;

   // States of the message sequencer.
   typedef enum logic [2:0] {
      SEQ_IDLE  = 3'b000,
      SEQ_HEAD  = 3'b001,
      SEQ_DATA  = 3'b010,
      SEQ_SUM   = 3'b011,
      SEQ_DRAIN = 3'b100,
      SEQ_WAIT  = 3'b101
   } seq_state_e;

endpackage

// [verif/obd_bus_model.sv]
// Diagnostic bus side: collects sent bytes and raises a reply edge on request.
// Assumes the builder's byte stream runs on the same clock.
`timescale 1ns/1ps
module obd_bus_model (
   input  wire logic       clock,
   input  wire logic       rst,
   input  wire logic [7:0] txData,
   input  wire logic       txValid,
   input  wire logic       txLast,
   output logic            txReady,
   output logic            replyIn,
   input  wire logic       slow,
   input  wire logic       answer
);
   logic [7:0] rxQ[$];
   logic [3:0] tickQ;
   // Takes bytes, stalling every other cycle when slow.
   always_ff @(posedge clock) begin
      tickQ <= rst ? 4'h0 : tickQ + 4'h1;
      txReady <= !slow || tickQ[0];
      if (txValid && txReady) rxQ.push_back(txData);
   end
   // Reply edge stands for the answer.
   always_ff @(posedge clock) begin
      if (rst || !answer) replyIn <= 1'b0;
      else if (txValid && txReady && txLast) replyIn <= 1'b1;
   end
endmodule

// [verif/obd_hdr_checker.sv]
// Port checker of the header builder: header acks, byte stream and first bytes.
// Assumes it is bound to the top module and shares its single clock.
`timescale 1ns/1ps
module obd_hdr_checker (
   input wire logic        clock,
   input wire logic        rst,
   input wire logic [7:0]  paddr,
   input wire logic        psel,
   input wire logic        penable,
   input wire logic        pwrite,
   input wire logic [31:0] pwdata,
   input wire logic [7:0]  txData,
   input wire logic        txValid,
   input wire logic        txFirst,
   input wire logic        txLast,
   input wire logic        txReady,
   input wire logic        headerOk,
   input wire logic        noReply
);
   logic [1:0] modeQ;
   logic       hdrWr;
   default clocking @(posedge clock); endclocking
   default disable iff (rst);
   // A header write targets one of the four set-header registers.
   assign hdrWr = psel && penable && pwrite && (paddr inside {8'h04, 8'h08, 8'h0C, 8'h10});
   // Mirrors the line mode written to the control register.
   always_ff @(posedge clock) begin
      if (rst) modeQ <= 2'b00;
      else if (psel && penable && pwrite && paddr == 8'h00) modeQ <= pwdata[1:0];
   end
   sequence s_hdrWr;
      hdrWr;
   endsequence
   sequence s_head;
      txValid && txFirst;
   endsequence
   property p_okAfterWr;
      s_hdrWr |=> headerOk;
   endproperty
   a_okAfterWr: assert property (p_okAfterWr) else $error("header write not acknowledged");
   property p_okCause;
      headerOk |-> $past(hdrWr);
   endproperty
   a_okCause: assert property (p_okCause) else $error("ack without header write");
   property p_hold;
      txValid && !txReady |=> txValid && $stable(txData) && $stable(txFirst);
   endproperty
   a_hold: assert property (p_hold) else $error("byte dropped while stalled");
   property p_lastEnd;
      txValid && txReady && txLast |=> !txValid [*2];
   endproperty
   a_lastEnd: assert property (p_lastEnd) else $error("bytes after the last one");
   property p_firstValid;
      txFirst |-> txValid && !txLast;
   endproperty
   a_firstValid: assert property (p_firstValid) else $error("first flag misplaced");
   property p_can29;
      s_head and (modeQ == 2'b10) |-> txData[7:5] == 3'b000;
   endproperty
   a_can29: assert property (p_can29) else $error("priority top bits sent");
   property p_can11;
      s_head and (modeQ == 2'b11) |-> txData[7:3] == 5'b00000;
   endproperty
   a_can11: assert property (p_can11) else $error("short id top bits sent");
   property p_kwp;
      s_head and (modeQ == 2'b01) |-> txData[5:3] == 3'b000;
   endproperty
   a_kwp: assert property (p_kwp) else $error("length byte middle bits set");
   property p_noReply;
      $rose(noReply) |-> !txValid && $past(!txValid, 2);
   endproperty
   a_noReply: assert property (p_noReply) else $error("no-reply during transmit");
endmodule

// [verif/obd_header_id_builder_tb_top.sv]
// Testbench of the header builder: APB tasks, frame checks and the verdict.
// Assumes the checker and bus model are compiled first.
`timescale 1ns/1ps
module obd_header_id_builder_tb_top;
   logic        clock = 1'b0;
   logic        rst = 1'b1;
   logic [7:0]  paddr = 8'h00;
   logic        psel = 1'b0;
   logic        penable = 1'b0;
   logic        pwrite = 1'b0;
   logic [31:0] pwdata = 32'h0000_0000;
   logic [31:0] prdata, r;
   logic [7:0]  txData;
   logic        pready, pslverr, replyIn, txValid, txFirst, txLast, txReady, err;
   logic        headerOk, noReply, headerDisplay;
   logic        answer = 1'b0;
   logic        slow = 1'b1;
   int          failures = 0;
   int          tests_run = 0;
   // Clock of 40 ns.
   always #20 clock = ~clock;
   obd_header_id_builder #(.TICK_CYCLES(8)) obd_header_id_builder_i (.clock(clock), .rst(rst),
      .paddr(paddr), .psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata),
      .prdata(prdata), .pready(pready), .pslverr(pslverr), .replyIn(replyIn),
      .txData(txData), .txValid(txValid), .txFirst(txFirst), .txLast(txLast),
      .txReady(txReady), .headerOk(headerOk), .noReply(noReply),
      .headerDisplay(headerDisplay));
   obd_bus_model obd_bus_model_i (.clock(clock), .rst(rst), .txData(txData),
      .txValid(txValid), .txLast(txLast), .txReady(txReady), .replyIn(replyIn),
      .slow(slow), .answer(answer));
   task automatic check(input logic [31:0] s, input logic [31:0] e);
      tests_run++;
      if (s !== e) begin
         failures++;
         $display("ERROR at %0t: seen %h expected %h", $time, s, e);
      end
   endtask
   task automatic apb(input logic [7:0] a, input logic w, input logic [31:0] d);
      @(posedge clock);
      psel <= 1'b1;
      penable <= 1'b0;
      paddr <= a;
      pwrite <= w;
      pwdata <= d;
      @(posedge clock);
      penable <= 1'b1;
      do @(posedge clock); while (pready !== 1'b1);
      r = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   task automatic rd(input logic [7:0] a, input logic [31:0] e);
      apb(a, 1'b0, 32'h0000_0000);
      check(r, e);
   endtask
   // Launches a frame, compares its bytes and polls until the builder is idle.
   task automatic frame(input logic [2:0] n, input logic [7:0] e[$]);
      obd_bus_model_i.rxQ.delete();
      apb(8'h1C, 1'b1, {29'h0, n});
      for (int k = 0; k < 300 && obd_bus_model_i.rxQ.size() < e.size(); k++) @(posedge clock);
      repeat (3) @(posedge clock);
      check(32'(obd_bus_model_i.rxQ.size()), 32'(e.size()));
      foreach (e[i]) check({24'h0, obd_bus_model_i.rxQ[i]}, {24'h0, e[i]});
      do apb(8'h18, 1'b0, 32'h0000_0000); while (r[3] !== 1'b0);
   endtask
   task automatic conclude;
      $display("Comparisons %0d, mismatches %0d", tests_run, failures);
      if (failures == 0 && tests_run > 0) $display("All checks passed");
      else $display("Checks failed");
      $finish;
   endtask
   // Watchdog against a hang.
   initial begin
      repeat (20000) @(posedge clock);
      failures++;
      conclude();
   end
   // Main sequence.
   initial begin
      repeat (2) @(posedge clock);
      rst <= 1'b0;
      rd(8'h10, 32'h0000_0018);
      rd(8'h04, 32'h0000_0000);
      apb(8'h14, 1'b1, 32'h0000_00FF);
      rd(8'h14, 32'h0000_00FF);
      apb(8'h14, 1'b1, 32'h0000_0000);
      apb(8'h04, 1'b1, 32'h00A8_48F1);
      apb(8'h20, 1'b1, 32'h0000_2010);
      frame(3'd1, '{8'hA8, 8'h48, 8'hF1, 8'h10, 8'hF1});
      check(noReply, 1'b1);
      slow <= 1'b0;
      answer <= 1'b1;
      apb(8'h00, 1'b1, 32'h0000_0001);
      apb(8'h04, 1'b1, 32'h0085_33F1);
      frame(3'd1, '{8'h81, 8'h33, 8'hF1, 8'h10, 8'hB5});
      check(r & 32'h0000_0006, 32'h0000_0004);
      answer <= 1'b0;
      apb(8'h04, 1'b1, 32'h00C0_33F1);
      answer <= 1'b1;
      frame(3'd2, '{8'hC0, 8'h33, 8'hF1, 8'h02, 8'h10, 8'h20, 8'h16});
      answer <= 1'b0;
      apb(8'h00, 1'b1, 32'h0000_0002);
      apb(8'h08, 1'b1, 32'hFFDB_33F1);
      rd(8'h10, 32'h0000_00FF);
      frame(3'd1, '{8'h1F, 8'hDB, 8'h33, 8'hF1, 8'h10});
      check(r & 32'h0000_0010, 32'h0000_0010);
      apb(8'h10, 1'b1, 32'h0000_0018);
      rd(8'h04, 32'h00DB_33F1);
      apb(8'h00, 1'b1, 32'h0000_0007);
      apb(8'h0C, 1'b1, 32'h0000_0FE0);
      rd(8'h0C, 32'h0000_07E0);
      frame(3'd1, '{8'h07, 8'hE0, 8'h10});
      apb(8'h0C, 1'b1, 32'h0000_07DF);
      apb(8'h18, 1'b0, 32'h0000_0000);
      check(r & 32'h0000_0010, 32'h0000_0010);
      apb(8'h40, 1'b1, 32'h0012_3456);
      check({err, headerDisplay}, 2'b11);
      rd(8'h04, 32'h0000_07DF);
      apb(8'h00, 1'b1, 32'h0000_000B);
      rd(8'h10, 32'h0000_0018);
      rd(8'h04, 32'h0000_0000);
      apb(8'h04, 1'b1, 32'h0012_3456);
      rst <= 1'b1;
      @(posedge clock);
      rst <= 1'b0;
      rd(8'h04, 32'h0000_0000);
      conclude();
   end
endmodule
bind obd_header_id_builder obd_hdr_checker obd_hdr_checker_i (.clock(clock), .rst(rst),
   .paddr(paddr), .psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata),
   .txData(txData), .txValid(txValid), .txFirst(txFirst), .txLast(txLast),
   .txReady(txReady), .headerOk(headerOk), .noReply(noReply));
